// *** logic/tmrc_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit timer/counter
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: Offsets are byte addresses on the local register port
package tmrc_pkg;
    // Register map
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_COUNT_LOW = 2'h1;
    localparam logic [1:0] ADDR_COUNT_HIGH = 2'h2;
    // Control register fields
    localparam int BIT_TIMER_RUN = 0;
    localparam int BIT_CLOCK_SOURCE = 1;
    localparam int BIT_EXT_SYNC_DISABLE = 2;
    localparam int BIT_OSC_ENABLE = 3;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_PRESCALE_HI = 5;
    localparam int BIT_SYSCLK_STATUS = 6;
    localparam int BIT_WIDE_ACCESS = 7;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // Instruction cycle is the system clock divided by four
    localparam int SYS_CLOCK_HZ = 10000000;
    localparam int INSTR_CLOCK_HZ = SYS_CLOCK_HZ / 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(SYS_CLOCK_HZ / INSTR_CLOCK_HZ - 1);
    // Operating modes, Gray coded
    typedef enum logic [1:0] {
        TMRC_MODE_TIMER = 2'h0,
        TMRC_MODE_SYNC_COUNT = 2'h1,
        TMRC_MODE_ASYNC_COUNT = 2'h3
    } tmrc_mode_t;
endpackage : tmrc_pkg

// *** logic/tmrc_prescale.sv ***
// Purpose: Divide-by-1/2/4/8 prescaler for count ticks
// Assumes: tick is a one-cycle pulse
// Notes: Counter is hidden from software, cleared by count writes
`timescale 1ns/10ps
module tmrc_prescale
    import tmrc_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic tick, // Input tick pulse
    input wire logic [1:0] prescale_select, // Division select
    input wire logic clear, // Clear the hidden counter
    output logic tick_out // Divided tick pulse
);
    logic [2:0] count;
    logic [2:0] mask;

    // Mask of low bits that must all be ones before a tick passes
    always_comb begin
        case (prescale_select)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
            default: mask = 3'h0;
        endcase
        tick_out = tick && ((count & mask) == mask);
    end

    // Hidden prescale counter
    always_ff @(posedge clock) begin
        if (!reset_n || clear) begin
            count <= 3'h0;
        end else if (tick) begin
            count <= count + 3'h1;
        end
    end
endmodule : tmrc_prescale

// *** logic/tmrc_edge.sv ***
// Purpose: Rising-edge detector for the external count input
// Assumes: raw input sampled on the system clock
// Notes: A falling edge must arm the detector before a rise counts
`timescale 1ns/10ps
module tmrc_edge
    import tmrc_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic raw_in, // Selected external clock level
    input wire logic use_sync, // Take the synchronised path
    input wire logic run, // Timer running
    input wire logic disarm, // Count write, forces re-arm
    output logic rise, // Counting rising edge pulse
    output logic armed // Falling edge seen
);
    logic sync_first;
    logic sync_second;
    logic level;
    logic prev_level;

    // Two-flop synchroniser; the first flop feeds only the second
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first <= raw_in;
            sync_second <= sync_first;
        end
    end

    // Unsynchronised mode skips the two-flop delay
    assign level = use_sync ? sync_second : raw_in;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level;
        end
    end

    // Arming: set by a falling edge while running, lost on write or on stop with input high
    always_ff @(posedge clock) begin
        if (!reset_n || disarm) begin
            armed <= 1'b0;
        end else if (run && prev_level && !level) begin
            armed <= 1'b1;
        end else if (!run && level) begin
            armed <= 1'b0;
        end
    end

    assign rise = armed && level && !prev_level;
endmodule : tmrc_edge

// *** logic/tmrc_top.sv ***
// Purpose: 16-bit timer/counter with prescaler and buffered 16-bit access
// Assumes: Register port strobes are one cycle, pins synchronous to clock
// Notes: Oscillator analog parts are outside; only their enable and level are seen
`timescale 1ns/10ps
module tmrc_top
    import tmrc_pkg::*;
(
    input wire logic clock, // 10 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [1:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic ext_count_input, // External clock pin level
    input wire logic osc_level, // Dedicated oscillator output level
    input wire logic sysclk_from_osc, // System clock runs from oscillator
    input wire logic event_trigger, // Compare-unit reset trigger pulse
    input wire logic [1:0] pin_level, // Levels of the two oscillator pins
    input wire logic [1:0] pin_direction, // Direction bits of those pins
    output logic osc_power_on, // Oscillator inverter and bias enable
    output logic [1:0] pin_read_value, // Pin levels as software sees them
    output logic [1:0] pin_direction_eff, // Direction bits after gating
    output logic overflow_flag, // Rollover event pulse
    output logic [15:0] count_value // Live count
);
    logic [7:0] timer_control;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [1:0] instr_div;
    logic instr_tick;
    logic timer_run;
    logic clock_source_select;
    logic ext_sync_disable;
    logic osc_enable;
    logic [1:0] prescale_select;
    logic wide_access_mode;
    logic sysclk_from_osc_status;
    logic ext_raw;
    logic ext_rise;
    logic ext_armed;
    logic source_tick;
    logic count_tick;
    logic write_low;
    logic write_high;
    logic read_low;
    logic count_write;
    logic next_wrap;
    tmrc_mode_t mode;

    // Control fields
    assign timer_run = timer_control[BIT_TIMER_RUN];
    assign clock_source_select = timer_control[BIT_CLOCK_SOURCE];
    assign ext_sync_disable = timer_control[BIT_EXT_SYNC_DISABLE];
    assign osc_enable = timer_control[BIT_OSC_ENABLE];
    assign prescale_select = timer_control[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
    assign wide_access_mode = timer_control[BIT_WIDE_ACCESS];
    assign sysclk_from_osc_status = sysclk_from_osc;

    // Register port decode
    assign write_low = reg_write && (reg_addr == ADDR_COUNT_LOW);
    assign write_high = reg_write && (reg_addr == ADDR_COUNT_HIGH);
    assign read_low = reg_read && (reg_addr == ADDR_COUNT_LOW);
    // High byte writes in wide mode only buffer, so they leave the prescaler alone
    assign count_write = write_low || (write_high && !wide_access_mode);

    // Mode from source and sync selects; sync bit ignored on the internal clock
    always_comb begin
        if (!clock_source_select) begin
            mode = TMRC_MODE_TIMER;
        end else if (ext_sync_disable) begin
            mode = TMRC_MODE_ASYNC_COUNT;
        end else begin
            mode = TMRC_MODE_SYNC_COUNT;
        end
    end

    // Control register; status bit is never stored
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            timer_control <= CONTROL_RESET;
        end else if (reg_write && (reg_addr == ADDR_CONTROL)) begin
            timer_control <= reg_wdata & CONTROL_WRITE_MASK;
        end
    end

    // Instruction cycle divider
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end
    assign instr_tick = (instr_div == INSTR_DIV_LAST);

    // The oscillator replaces the pin as external source when enabled
    assign ext_raw = osc_enable ? osc_level : ext_count_input;

    tmrc_edge u_edge (
        .clock(clock),
        .reset_n(reset_n),
        .raw_in(ext_raw),
        .use_sync(mode != TMRC_MODE_ASYNC_COUNT),
        .run(timer_run),
        .disarm(count_write),
        .rise(ext_rise),
        .armed(ext_armed)
    );

    // Source select, gated by run so a stopped timer does not move the prescaler
    always_comb begin
        case (mode)
            TMRC_MODE_TIMER: source_tick = instr_tick;
            TMRC_MODE_SYNC_COUNT: source_tick = ext_rise;
            TMRC_MODE_ASYNC_COUNT: source_tick = ext_rise;
            default: source_tick = 1'b0;
        endcase
    end

    tmrc_prescale u_prescale (
        .clock(clock),
        .reset_n(reset_n),
        .tick(source_tick && timer_run),
        .prescale_select(prescale_select),
        .clear(count_write),
        .tick_out(count_tick)
    );

    assign next_wrap = count_tick && (count == COUNT_MAX);

    // Count register: write beats trigger, trigger beats increment
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count <= COUNT_RESET;
        end else if (write_low && wide_access_mode) begin
            count <= {high_buffer, reg_wdata};
        end else if (write_low) begin
            count[7:0] <= reg_wdata;
        end else if (write_high && !wide_access_mode) begin
            count[15:8] <= reg_wdata;
        end else if (event_trigger && (mode != TMRC_MODE_ASYNC_COUNT)) begin
            count <= COUNT_RESET;
        end else if (count_tick) begin
            count <= count + 16'h0001;
        end
    end

    // High byte buffer for wide access
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            high_buffer <= 8'h00;
        end else if (write_high && wide_access_mode) begin
            high_buffer <= reg_wdata;
        end else if (read_low && wide_access_mode) begin
            high_buffer <= count[15:8];
        end
    end

    // Overflow event; the compare trigger never raises it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            overflow_flag <= 1'b0;
        end else begin
            // Only a write that loads the count, or a clearing trigger, hides the wrap
            overflow_flag <= next_wrap && !count_write
                && !(event_trigger && (mode != TMRC_MODE_ASYNC_COUNT));
        end
    end

    // Read data from registered state, so async counting cannot tear a byte
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_CONTROL: reg_rdata <= {timer_control[7], sysclk_from_osc_status, timer_control[5:0]};
                ADDR_COUNT_LOW: reg_rdata <= count[7:0];
                ADDR_COUNT_HIGH: reg_rdata <= wide_access_mode ? high_buffer : count[15:8];
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Pin side: oscillator owns the pins while enabled
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            osc_power_on <= 1'b0;
            pin_read_value <= 2'h0;
            pin_direction_eff <= 2'h0;
        end else begin
            osc_power_on <= osc_enable;
            pin_read_value <= osc_enable ? 2'h0 : pin_level;
            pin_direction_eff <= osc_enable ? 2'h0 : pin_direction;
        end
    end

    // Live count for observers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_value <= COUNT_RESET;
        end else begin
            count_value <= count;
        end
    end

    // Checks
    // Prescale ratio seen from outside; assumes it only changes before a count write
    logic [3:0] check_ticks;
    logic [3:0] check_ratio;

    // Expected divisor from the select field
    always_comb begin
        case (prescale_select)
            2'h0: check_ratio = 4'h1;
            2'h1: check_ratio = 4'h2;
            2'h2: check_ratio = 4'h4;
            2'h3: check_ratio = 4'h8;
            default: check_ratio = 4'h1;
        endcase
    end

    // Input ticks since the last count step
    always_ff @(posedge clock) begin
        if (!reset_n || count_write || count_tick) begin
            check_ticks <= 4'h0;
        end else if (source_tick && timer_run) begin
            check_ticks <= check_ticks + 4'h1;
        end
    end

    a_prescale_ratio: assert property (@(posedge clock) disable iff (!reset_n)
        (source_tick && timer_run && !count_write) |-> count_tick == (check_ticks + 4'h1 == check_ratio))
        else $error("prescale ratio wrong");

    sequence s_wide_low_read;
        reg_read && (reg_addr == ADDR_COUNT_LOW) && wide_access_mode;
    endsequence

    sequence s_high_read_next;
        ##1 reg_read && (reg_addr == ADDR_COUNT_HIGH) && !reg_write;
    endsequence

    a_hold_stopped: assert property (@(posedge clock) disable iff (!reset_n)
        (!timer_run && !reg_write && !event_trigger) |=> count == $past(count))
        else $error("count moved while stopped");

    a_wrap_zero: assert property (@(posedge clock) disable iff (!reset_n)
        (next_wrap && !reg_write && !event_trigger) |=> (count == COUNT_RESET) && overflow_flag)
        else $error("rollover did not wrap or flag");

    a_status_read: assert property (@(posedge clock) disable iff (!reset_n)
        (reg_read && (reg_addr == ADDR_CONTROL)) |=> reg_rdata[BIT_SYSCLK_STATUS] == $past(sysclk_from_osc))
        else $error("status bit wrong");

    a_prescale_clear: assert property (@(posedge clock) disable iff (!reset_n)
        count_write |=> u_prescale.count == 3'h0)
        else $error("prescaler not cleared");

    a_osc_pins: assert property (@(posedge clock) disable iff (!reset_n)
        osc_enable |=> (pin_read_value == 2'h0) && (pin_direction_eff == 2'h0))
        else $error("pins not gated");

    a_wide_write: assert property (@(posedge clock) disable iff (!reset_n)
        (write_low && wide_access_mode) |=> count == {$past(high_buffer), $past(reg_wdata)})
        else $error("wide write did not load both bytes");

    a_wide_read: assert property (@(posedge clock) disable iff (!reset_n)
        s_wide_low_read ##0 s_high_read_next
        |=> reg_rdata == $past(count[15:8], 2))
        else $error("high read did not return buffer");

    a_trigger_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (event_trigger && !reg_write && (mode != TMRC_MODE_ASYNC_COUNT)) |=> count == COUNT_RESET)
        else $error("trigger did not clear count");

    a_write_disarm: assert property (@(posedge clock) disable iff (!reset_n)
        (count_write && clock_source_select) |=> !ext_armed ##1 !count_tick)
        else $error("write did not disarm edge");

    a_timer_rate: assert property (@(posedge clock) disable iff (!reset_n)
        (count_tick && (mode == TMRC_MODE_TIMER) && (prescale_select == 2'h0)) |=> !count_tick [*3])
        else $error("timer ticks faster than instruction clock");

    a_osc_power: assert property (@(posedge clock) disable iff (!reset_n)
        osc_power_on == $past(osc_enable))
        else $error("oscillator power wrong");

    a_reset_clear: assert property (@(posedge clock)
        !reset_n |=> (timer_control == CONTROL_RESET) && (count == COUNT_RESET))
        else $error("reset left state");

    a_byte_low: assert property (@(posedge clock) disable iff (!reset_n)
        (write_low && !wide_access_mode) |=> count[7:0] == $past(reg_wdata))
        else $error("low write lost");

    a_byte_high: assert property (@(posedge clock) disable iff (!reset_n)
        (write_high && !wide_access_mode) |=> count[15:8] == $past(reg_wdata))
        else $error("high write lost");

    a_wide_high_hold: assert property (@(posedge clock) disable iff (!reset_n)
        (write_high && wide_access_mode && !count_tick && !event_trigger) |=> $stable(count))
        else $error("buffered write hit count");

    a_unarmed_quiet: assert property (@(posedge clock) disable iff (!reset_n)
        (clock_source_select && !ext_armed) |-> !count_tick)
        else $error("count before falling edge");

    a_low_read: assert property (@(posedge clock) disable iff (!reset_n)
        (reg_read && (reg_addr == ADDR_COUNT_LOW)) |=> reg_rdata == $past(count[7:0]))
        else $error("low read wrong");

    a_overflow_once: assert property (@(posedge clock) disable iff (!reset_n)
        overflow_flag |=> !overflow_flag)
        else $error("overflow too long");

    a_async_no_trigger: assert property (@(posedge clock) disable iff (!reset_n)
        (event_trigger && (mode == TMRC_MODE_ASYNC_COUNT) && !count_write && !count_tick) |=> $stable(count))
        else $error("trigger acted in async mode");
endmodule : tmrc_top

// *** bench/tmrc_ext_model.sv ***
// Purpose: Model of the external count pin and the crystal oscillator
// Assumes: Frames are requested one at a time by the bench
// Notes: The unselected line toggles every cycle, so a wrong source shows
`timescale 1ns/10ps
module tmrc_ext_model (
    input wire logic clock, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic osc_on, // Oscillator powered by the block
    input wire logic go, // Start a frame
    input wire logic [7:0] pulses, // Rising edges in the frame
    input wire logic rest_high, // Level held between frames
    output logic ext_level, // External count pin
    output logic osc_out, // Oscillator output
    output logic busy // Frame in progress
);
    // Sync mode needs at least three clocks high and low
    localparam int HALF = 4;
    logic wave;
    logic toggle;
    // Filler for the line that is not selected, never steady
    always_ff @(posedge clock) begin
        toggle <= reset_n ? ~toggle : 1'b0;
    end
    // Each pulse is low then high; the line stands still outside frames
    always @(posedge clock) begin
        if (!reset_n) begin
            busy <= 1'b0;
            wave <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            repeat (pulses) begin
                wave <= 1'b0;
                repeat (HALF) @(posedge clock);
                wave <= 1'b1;
                repeat (HALF) @(posedge clock);
            end
            wave <= rest_high;
            busy <= 1'b0;
        end else begin
            wave <= rest_high;
        end
    end
    // Crystal takes over from the pin while powered
    assign ext_level = osc_on ? toggle : wave;
    assign osc_out = osc_on ? wave : toggle;
endmodule : tmrc_ext_model

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the 16-bit timer/counter
// Assumes: Register port answers one cycle after the read strobe
// Notes: Timer counts get a one-count margin for tick phase
`timescale 1ns/10ps
module tb_top
    import tmrc_pkg::*;
();
    localparam int LIMIT = 20000;
    typedef struct {logic [7:0] ctrl; logic rest; logic [7:0] n; logic [7:0] exp;} tmrc_row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_count_input;
    logic osc_level;
    logic sysclk_from_osc = 1'b0;
    logic event_trigger = 1'b0;
    logic [1:0] pin_level = 2'h2;
    logic [1:0] pin_direction = 2'h1;
    logic osc_power_on;
    logic [1:0] pin_read_value;
    logic [1:0] pin_direction_eff;
    logic overflow_flag;
    logic [15:0] count_value;
    logic go = 1'b0;
    logic [7:0] pulses = 8'h00;
    logic rest_high = 1'b0;
    logic busy;
    logic [7:0] rd_val;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // Control, resting level, edges sent, count expected
    tmrc_row_t rows [8] = '{
        '{8'h03, 1'b1, 8'h08, 8'h08}, // Sync counter
        '{8'h07, 1'b1, 8'h08, 8'h08}, // Async counter
        '{8'h13, 1'b1, 8'h08, 8'h04}, // Divide by two
        '{8'h23, 1'b1, 8'h08, 8'h02}, // Divide by four
        '{8'h33, 1'b1, 8'h10, 8'h02}, // Divide by eight
        '{8'h0B, 1'b1, 8'h08, 8'h08}, // Oscillator edges
        '{8'h03, 1'b0, 8'h08, 8'h07}, // First rise unarmed
        '{8'h02, 1'b1, 8'h08, 8'h00} // Stopped
    };
    always #50 clock = ~clock;
    tmrc_top dut (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .ext_count_input(ext_count_input), .osc_level(osc_level), .sysclk_from_osc(sysclk_from_osc),
        .event_trigger(event_trigger), .pin_level(pin_level), .pin_direction(pin_direction),
        .osc_power_on(osc_power_on), .pin_read_value(pin_read_value),
        .pin_direction_eff(pin_direction_eff), .overflow_flag(overflow_flag), .count_value(count_value)
    );
    tmrc_ext_model partner (
        .clock(clock), .reset_n(reset_n), .osc_on(osc_power_on), .go(go), .pulses(pulses),
        .rest_high(rest_high), .ext_level(ext_count_input), .osc_out(osc_level), .busy(busy)
    );
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            final_report();
        end
    end
    task chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task chk_rng(input string name, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] seen);
        checks_done++;
        if ((^seen === 1'bx) || seen < lo || seen > hi) begin
            miscompares++;
            $display("unexpected %s expected %h to %h seen %h", name, lo, hi, seen);
        end
    endtask : chk_rng
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd
    // Stop before touching the count, then clear it and start
    task setup(input logic [7:0] ctrl, input logic rest);
        wr(ADDR_CONTROL, ctrl & 8'hFE);
        rest_high <= rest;
        repeat (3) @(posedge clock);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_CONTROL, ctrl);
    endtask : setup
    task frame(input logic [7:0] n);
        @(posedge clock);
        pulses <= n;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clock);
        repeat (8) @(posedge clock);
    endtask : frame
    task expect_rd(input string name, input logic [1:0] a, input logic [7:0] exp);
        rd(a, rd_val);
        chk(name, 16'(exp), 16'(rd_val));
    endtask : expect_rd
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        // Reset state and unmapped address
        expect_rd("control reset", ADDR_CONTROL, 8'h00);
        expect_rd("count low reset", ADDR_COUNT_LOW, 8'h00);
        expect_rd("count high reset", ADDR_COUNT_HIGH, 8'h00);
        expect_rd("unmapped read", 2'h3, 8'h00);
        @(posedge clock);
        chk("read data idle", 16'h0000, 16'(reg_rdata));
        chk("osc off at reset", 16'h0000, 16'(osc_power_on));
        // Status bit is read-only and follows the clock source
        wr(ADDR_CONTROL, 8'hFF);
        wr(2'h3, 8'h00);
        expect_rd("control status low", ADDR_CONTROL, 8'hBF);
        sysclk_from_osc <= 1'b1;
        expect_rd("control status high", ADDR_CONTROL, 8'hFF);
        chk("osc powered", 16'h0001, 16'(osc_power_on));
        chk("pins gated", 16'h0000, 16'(pin_read_value));
        chk("direction gated", 16'h0000, 16'(pin_direction_eff));
        sysclk_from_osc <= 1'b0;
        wr(ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge clock);
        chk("osc shut off", 16'h0000, 16'(osc_power_on));
        chk("pins live", 16'h0002, 16'(pin_read_value));
        chk("direction live", 16'h0001, 16'(pin_direction_eff));
        // Ordinary counting cases
        foreach (rows[i]) begin
            setup(rows[i].ctrl, rows[i].rest);
            frame(rows[i].n);
            expect_rd("row count", ADDR_COUNT_LOW, rows[i].exp);
        end
        // Prescaler residue must not survive a count write
        setup(8'h13, 1'b1);
        frame(8'h01);
        wr(ADDR_COUNT_LOW, 8'h00);
        frame(8'h01);
        expect_rd("prescaler cleared", ADDR_COUNT_LOW, 8'h00);
        // Wide access through the high byte buffer
        setup(8'h00, 1'b0);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_HIGH, 8'h12);
        repeat (2) @(posedge clock);
        chk("wide high only buffered", 16'h0000, count_value);
        wr(ADDR_COUNT_LOW, 8'h34);
        repeat (2) @(posedge clock);
        chk("wide write both", 16'h1234, count_value);
        wr(ADDR_COUNT_HIGH, 8'h77);
        expect_rd("wide high is buffer", ADDR_COUNT_HIGH, 8'h77);
        expect_rd("wide low", ADDR_COUNT_LOW, 8'h34);
        expect_rd("wide high latched", ADDR_COUNT_HIGH, 8'h12);
        // Back-to-back reads: low read must replace the stale buffer
        wr(ADDR_COUNT_HIGH, 8'h99);
        @(posedge clock);
        reg_addr <= ADDR_COUNT_LOW;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_addr <= ADDR_COUNT_HIGH;
        @(posedge clock);
        reg_read <= 1'b0;
        chk("pair low", 16'h0034, 16'(reg_rdata));
        @(posedge clock);
        chk("pair high", 16'h0012, 16'(reg_rdata));
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h56);
        repeat (2) @(posedge clock);
        chk("byte high direct", 16'h5634, count_value);
        // Instruction clock rate; sync bit ignored on internal source
        foreach (rows[i]) begin
            if (i < 2) begin
                setup(i == 0 ? 8'h21 : 8'h25, 1'b0);
                repeat (160) @(posedge clock);
                wr(ADDR_CONTROL, 8'h00);
                rd(ADDR_COUNT_LOW, rd_val);
                chk_rng("timer count", 16'h0009, 16'h000B, 16'(rd_val));
            end
        end
        // Rollover pulse
        wr(ADDR_COUNT_LOW, 8'hFF);
        wr(ADDR_COUNT_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h01);
        for (int i = 0; i < 20 && overflow_flag !== 1'b1; i++) @(posedge clock);
        chk("overflow", 16'h0001, 16'(overflow_flag));
        @(posedge clock);
        chk("overflow one cycle", 16'h0000, 16'(overflow_flag));
        chk("wrap count", 16'h0000, count_value);
        // Trigger clears in timer mode, not in async mode, and loses to a write
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_CONTROL, m == 0 ? 8'h00 : 8'h06);
            wr(ADDR_COUNT_LOW, 8'h42);
            wr(ADDR_COUNT_HIGH, 8'h00);
            @(posedge clock);
            event_trigger <= 1'b1;
            @(posedge clock);
            event_trigger <= 1'b0;
            repeat (3) @(posedge clock);
            chk("trigger", m == 0 ? 16'h0000 : 16'h0042, count_value);
        end
        wr(ADDR_CONTROL, 8'h00);
        @(posedge clock);
        reg_addr <= ADDR_COUNT_LOW;
        reg_wdata <= 8'h55;
        reg_write <= 1'b1;
        event_trigger <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        event_trigger <= 1'b0;
        repeat (2) @(posedge clock);
        chk("write beats trigger", 16'h0055, count_value);
        final_report();
    end
endmodule : tb_top
